// [dpg_top.sv]
// Two-port GPIO block with AXI4-Lite register access
//
// Notes on behaviour
// - Direction change with functions on may raise events
// - Port A direction bit: one output, zero input
// - All pin inputs pass Schmitt-trigger buffers
// - Port A function bit selects open-drain output
// - Port B five lines, direction set per bit
// - Port B alternate inputs only when function set
// - Pin0 recovery, pin2 int three, pin4 ints one/four
// - Pin inputs pass two flip-flops before register
// - Output bits drive output register; read returns it
// - Input bit write overwritten next cycle by sample
// - Output bit input register keeps written value
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
module dpg_top #(
  parameter int PA_W = dpg_pkg::PA_BITS,  // Port A width
  parameter int PB_W = dpg_pkg::PB_BITS   // Port B width
) (
  input  wire logic                       i_clk_sys,        // System clock
  input  wire logic                       i_rst,            // Synchronous reset
  // AXI4-Lite slave
  input  wire logic [dpg_pkg::ADDR_W-1:0] i_s_axi_awaddr,   // Write address
  input  wire logic                       i_s_axi_awvalid,  // Write address valid
  output logic                            o_s_axi_awready,  // Write address ready
  input  wire logic [dpg_pkg::DATA_W-1:0] i_s_axi_wdata,    // Write data
  input  wire logic [3:0]                 i_s_axi_wstrb,    // Byte enables
  input  wire logic                       i_s_axi_wvalid,   // Write data valid
  output logic                            o_s_axi_wready,   // Write data ready
  output logic [1:0]                      o_s_axi_bresp,    // Write response
  output logic                            o_s_axi_bvalid,   // Write response valid
  input  wire logic                       i_s_axi_bready,   // Write response ready
  input  wire logic [dpg_pkg::ADDR_W-1:0] i_s_axi_araddr,   // Read address
  input  wire logic                       i_s_axi_arvalid,  // Read address valid
  output logic                            o_s_axi_arready,  // Read address ready
  output logic [dpg_pkg::DATA_W-1:0]      o_s_axi_rdata,    // Read data
  output logic [1:0]                      o_s_axi_rresp,    // Read response
  output logic                            o_s_axi_rvalid,   // Read data valid
  input  wire logic                       i_s_axi_rready,   // Read data ready
  // Port A pins
  input  wire logic [PA_W-1:0]            i_pa_pin,         // Port A pin level
  output logic [PA_W-1:0]                 o_pa_pin,         // Port A drive value
  output logic [PA_W-1:0]                 o_pa_pin_oe,      // Port A drive enable
  // Port B pins
  input  wire logic [PB_W-1:0]            i_pb_pin,         // Port B pin level
  output logic [PB_W-1:0]                 o_pb_pin,         // Port B drive value
  output logic [PB_W-1:0]                 o_pb_pin_oe,      // Port B drive enable
  // Special-function requests, active high while pin is low
  output logic                            o_portb_pin_zero_recovery,   // Stop-mode recovery
  output logic                            o_external_interrupt_three,  // Interrupt three
  output logic                            o_external_interrupt_one_four // Interrupts one/four
);

  // Elaboration-time width check
  if (PA_W < 1 || PA_W > 8 || PB_W < dpg_pkg::PB_INT_1_4 + 1 || PB_W > 8) begin : g_bad_width
    $error("dpg_top: port widths out of range");
  end

  // Register selector from a byte address; unmapped gives 4'hF
  function automatic logic [3:0] reg_sel(input logic [dpg_pkg::ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[dpg_pkg::ADDR_W-1:2];
    reg_sel = 4'hF;
    if (idx[9:3] == 7'(dpg_pkg::IDX_PA_IN >> 3)) begin
      reg_sel = {1'b0, idx[2:0]};
    end
  endfunction

  // Register file
  logic [PA_W-1:0] port_a_in;                    // Port A input value
  logic [PA_W-1:0] port_a_out;                   // Port A output value
  logic [PA_W-1:0] port_a_direction_reg;         // Port A direction
  logic [PA_W-1:0] port_a_special_function_reg;  // Port A push-pull/open-drain
  logic [PB_W-1:0] port_b_in;                    // Port B input value
  logic [PB_W-1:0] port_b_out;                   // Port B output value
  logic [PB_W-1:0] port_b_direction_reg;         // Port B direction
  logic [PB_W-1:0] port_b_special_function_reg;  // Port B alternate input enables

  // Synchroniser stages
  logic [PA_W-1:0] pa_meta;   // First stage, Port A
  logic [PA_W-1:0] pa_sync;   // Second stage, Port A
  logic [PB_W-1:0] pb_meta;   // First stage, Port B
  logic [PB_W-1:0] pb_sync;   // Second stage, Port B

  // Write channel state
  logic                       aw_held;   // Address captured
  logic [dpg_pkg::ADDR_W-1:0] aw_addr;   // Captured address
  logic                       w_held;    // Data captured
  logic [7:0]                 w_data;    // Captured low byte
  logic                       w_lane0;   // Low byte enabled
  logic                       do_write;  // Both halves present
  logic [3:0]                 wr_sel;    // Target register
  logic [3:0]                 rd_sel;    // Read target register

  // Handshake readies
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_held && !o_s_axi_bvalid;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  assign do_write        = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_sel          = reg_sel(aw_addr);
  assign rd_sel          = reg_sel(i_s_axi_araddr);

  // Capture write address and data in either order
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= i_s_axi_wdata[7:0];
        w_lane0 <= i_s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped address
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= dpg_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= wr_sel[3] ? dpg_pkg::RESP_SLVERR : dpg_pkg::RESP_OKAY;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // Control and output registers, written on the edge after capture
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      port_a_out                  <= PA_W'(dpg_pkg::RST_VAL);
      port_a_direction_reg        <= PA_W'(dpg_pkg::RST_DIR);
      port_a_special_function_reg <= PA_W'(dpg_pkg::RST_SFR);
      port_b_out                  <= PB_W'(dpg_pkg::RST_VAL);
      port_b_direction_reg        <= PB_W'(dpg_pkg::RST_DIR);
      port_b_special_function_reg <= PB_W'(dpg_pkg::RST_SFR);
    end else if (do_write && w_lane0) begin
      case (wr_sel)
        4'h1: port_a_out                  <= w_data[PA_W-1:0];
        4'h2: port_a_direction_reg        <= w_data[PA_W-1:0];
        4'h3: port_a_special_function_reg <= w_data[PA_W-1:0];
        4'h5: port_b_out                  <= w_data[PB_W-1:0];
        4'h6: port_b_direction_reg        <= w_data[PB_W-1:0];
        4'h7: port_b_special_function_reg <= w_data[PB_W-1:0];
        default: ;
      endcase
    end
  end

  // Two-stage synchronisers behind the Schmitt-trigger pin buffers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      // Idle high like released pins, so no false low request after reset
      pa_meta <= '1;
      pa_sync <= '1;
      pb_meta <= '1;
      pb_sync <= '1;
    end else begin
      pa_meta <= i_pa_pin;
      pa_sync <= pa_meta;
      pb_meta <= i_pb_pin;
      pb_sync <= pb_meta;
    end
  end

  // Input value registers: inputs sample, outputs keep written value
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      port_a_in <= PA_W'(dpg_pkg::RST_VAL);
      port_b_in <= PB_W'(dpg_pkg::RST_VAL);
    end else begin
      for (int i = 0; i < PA_W; i++) begin
        if (do_write && w_lane0 && wr_sel == 4'h0) begin
          port_a_in[i] <= w_data[i];
        end else if (!port_a_direction_reg[i]) begin
          port_a_in[i] <= pa_sync[i];
        end
      end
      for (int i = 0; i < PB_W; i++) begin
        if (do_write && w_lane0 && wr_sel == 4'h4) begin
          port_b_in[i] <= w_data[i];
        end else if (!port_b_direction_reg[i]) begin
          port_b_in[i] <= pb_sync[i];
        end
      end
    end
  end

  // Pin drivers: open-drain drives only a low
  genvar g;
  for (g = 0; g < PA_W; g++) begin : g_pa_drv
    assign o_pa_pin[g]    = port_a_out[g];
    assign o_pa_pin_oe[g] = port_a_direction_reg[g] &&
                            (!port_a_special_function_reg[g] || !port_a_out[g]);
  end
  assign o_pb_pin    = port_b_out;
  assign o_pb_pin_oe = port_b_direction_reg;

  // Special-function requests from synchronised low levels on input pins
  always_comb begin
    o_portb_pin_zero_recovery = port_b_special_function_reg[dpg_pkg::PB_RECOVERY] &&
                                !port_b_direction_reg[dpg_pkg::PB_RECOVERY] &&
                                !pb_sync[dpg_pkg::PB_RECOVERY];
    o_external_interrupt_three = port_b_special_function_reg[dpg_pkg::PB_INT_3] &&
                                 !port_b_direction_reg[dpg_pkg::PB_INT_3] &&
                                 !pb_sync[dpg_pkg::PB_INT_3];
    o_external_interrupt_one_four = port_b_special_function_reg[dpg_pkg::PB_INT_1_4] &&
                                    !port_b_direction_reg[dpg_pkg::PB_INT_1_4] &&
                                    !pb_sync[dpg_pkg::PB_INT_1_4];
  end

  // Read channel: one read at a time, data registered
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= '0;
      o_s_axi_rresp  <= dpg_pkg::RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= rd_sel[3] ? dpg_pkg::RESP_SLVERR : dpg_pkg::RESP_OKAY;
      case (rd_sel)
        4'h0: o_s_axi_rdata <= 32'(port_a_in);
        4'h1: o_s_axi_rdata <= 32'(port_a_out);
        4'h2: o_s_axi_rdata <= 32'(port_a_direction_reg);
        4'h3: o_s_axi_rdata <= 32'(port_a_special_function_reg);
        4'h4: o_s_axi_rdata <= 32'(port_b_in);
        4'h5: o_s_axi_rdata <= 32'(port_b_out);
        4'h6: o_s_axi_rdata <= 32'(port_b_direction_reg);
        4'h7: o_s_axi_rdata <= 32'(port_b_special_function_reg);
        default: o_s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [dpg_pkg.sv]
// Constants shared by the two-port GPIO block
package dpg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PA_IN   = 8'hD0;  // Port A input value
  localparam logic [7:0]  IDX_PA_OUT  = 8'hD1;  // Port A output value
  localparam logic [7:0]  IDX_PA_DIR  = 8'hD2;  // Port A direction
  localparam logic [7:0]  IDX_PA_SFR  = 8'hD3;  // Port A special function
  localparam logic [7:0]  IDX_PB_IN   = 8'hD4;  // Port B input value
  localparam logic [7:0]  IDX_PB_OUT  = 8'hD5;  // Port B output value
  localparam logic [7:0]  IDX_PB_DIR  = 8'hD6;  // Port B direction
  localparam logic [7:0]  IDX_PB_SFR  = 8'hD7;  // Port B special function
  // Bus geometry
  localparam int          ADDR_W      = 12;     // Byte address width
  localparam int          DATA_W      = 32;     // Bus data width
  // Documented port widths
  localparam int          PA_BITS     = 8;      // Port A lines
  localparam int          PB_BITS     = 5;      // Port B lines
  // Port B special-function bit positions
  localparam int          PB_RECOVERY = 0;      // Stop-mode recovery input
  localparam int          PB_INT_3    = 2;      // External interrupt three
  localparam int          PB_INT_1_4  = 4;      // Shared interrupts one and four
  // Values after reset
  localparam logic [7:0]  RST_DIR     = 8'h00;  // All pins inputs
  localparam logic [7:0]  RST_SFR     = 8'h00;  // Special functions off
  localparam logic [7:0]  RST_VAL     = 8'h00;  // Value registers cleared
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;   // Access done
  localparam logic [1:0]  RESP_SLVERR = 2'h2;   // Unmapped address
endpackage

// [dpg_assertions.sv]
// Port-level checker for the two-port GPIO block
`timescale 1ns/100ps
module dpg_assertions #(
  parameter int PA_W = 8,  // Port A width
  parameter int PB_W = 5   // Port B width
) (
  input wire logic            i_clk_sys, i_rst, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid,
  input wire logic            o_s_axi_wready, o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid,
  input wire logic            o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready,
  input wire logic [1:0]      o_s_axi_bresp,
  input wire logic [31:0]     o_s_axi_rdata,
  input wire logic [PA_W-1:0] o_pa_pin, o_pa_pin_oe,
  input wire logic [PB_W-1:0] i_pb_pin, o_pb_pin, o_pb_pin_oe,
  input wire logic            o_portb_pin_zero_recovery, o_external_interrupt_three,
  input wire logic            o_external_interrupt_one_four
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Requests need an input pin seen low two edges back
  rec_req_a: assert property (o_portb_pin_zero_recovery |-> !o_pb_pin_oe[0] && !$past(i_pb_pin[0], 2))
    else $error("recovery request without low input");
  int3_req_a: assert property (o_external_interrupt_three |-> !o_pb_pin_oe[2] && !$past(i_pb_pin[2], 2))
    else $error("interrupt three request without low input");
  int14_req_a: assert property (o_external_interrupt_one_four |-> !o_pb_pin_oe[4] && !$past(i_pb_pin[4], 2))
    else $error("interrupt one four request without low input");
  // Pins move only with a completed write
  pin_write_a: assert property (
    $changed({o_pa_pin, o_pa_pin_oe, o_pb_pin, o_pb_pin_oe}) |-> $rose(o_s_axi_bvalid))
    else $error("pin drive changed without write");
  bresp_hold_a: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");
  read_lat_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  write_lat_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
    else $error("write answer not two edges after");
  wr_c: cover property (o_s_axi_bvalid && i_s_axi_bready);
  rd_c: cover property (o_s_axi_rvalid && i_s_axi_rready);
  rec_c: cover property (o_portb_pin_zero_recovery && o_external_interrupt_one_four);
endmodule

// [dpg_pins.sv]
// Board model: pin drivers, external sources and pull-ups
`timescale 1ns/100ps
module dpg_pins #(
  parameter int W = 8  // Pin count
) (
  input  wire logic [W-1:0] i_drv,     // Block drive value
  input  wire logic [W-1:0] i_oe,      // Block drive enable
  input  wire logic [W-1:0] i_ext,     // External source value
  input  wire logic [W-1:0] i_ext_en,  // External source enable
  output logic      [W-1:0] o_level    // Resolved level
);
  // Block wins, then source, else pull-up, so released lines read high
  assign o_level = (i_oe & i_drv) | (~i_oe & ((i_ext_en & i_ext) | ~i_ext_en));
endmodule

// [test_dual_port_gpio_special_functions.sv]
// Self-checking bench for the two-port GPIO block
`timescale 1ns/100ps
module test_dual_port_gpio_special_functions;
  logic i_clk_sys = 0, i_rst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid, o_portb_pin_zero_recovery, o_external_interrupt_three;
  logic o_external_interrupt_one_four;
  logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
  logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [7:0]  i_pa_pin, o_pa_pin, o_pa_pin_oe;
  logic [4:0]  i_pb_pin, o_pb_pin, o_pb_pin_oe;
  logic [7:0]  m [8] = '{default: 0};   // Register model
  logic [7:0]  ev [2] = '{default: 0};  // External source values
  logic [7:0]  ee [2] = '{default: 0};  // External source enables
  int          n_fail = 0, total_checks = 0, seed = 52243;
  dpg_top uut (.i_clk_sys, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
    .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .i_pa_pin, .o_pa_pin, .o_pa_pin_oe, .i_pb_pin, .o_pb_pin, .o_pb_pin_oe,
    .o_portb_pin_zero_recovery, .o_external_interrupt_three, .o_external_interrupt_one_four);
  dpg_pins #(.W(8)) pa (.i_drv(o_pa_pin), .i_oe(o_pa_pin_oe), .i_ext(ev[0]), .i_ext_en(ee[0]), .o_level(i_pa_pin));
  dpg_pins #(.W(5)) pb (.i_drv(o_pb_pin), .i_oe(o_pb_pin_oe), .i_ext(ev[1][4:0]), .i_ext_en(ee[1][4:0]),
    .o_level(i_pb_pin));
  always #10 i_clk_sys = ~i_clk_sys;
  // Expected pin level; open-drain A bits release when high
  function automatic logic [7:0] lvl(int p);
    logic [7:0] oe;
    oe = p ? m[6] : m[2] & ~(m[3] & m[1]);
    return (oe & m[4*p+1]) | (~oe & ((ee[p] & ev[p]) | ~ee[p]));
  endfunction
  // Expected read: input bits show pin, output bits keep written value
  function automatic logic [7:0] exp_rd(int k);
    if (k % 4 != 0) return m[k];
    return (m[k] & m[k+2]) | (lvl(k / 4) & ~m[k+2] & (k ? 8'h1F : 8'hFF));
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus write, both channels offered together
  task automatic wr(int a, logic [31:0] d, logic [1:0] er);
    bit pa, pw;
    pa = 1;
    pw = 1;
    i_s_axi_awaddr <= 12'(a * 4);
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge i_clk_sys);
      if (pa && o_s_axi_awready) begin
        pa = 0;
        i_s_axi_awvalid <= 1'h0;
      end
      if (pw && o_s_axi_wready) begin
        pw = 0;
        i_s_axi_wvalid <= 1'h0;
      end
    end
    i_s_axi_bready <= 1'h1;
    do @(posedge i_clk_sys); while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(o_s_axi_bresp));
    if (er != dpg_pkg::RESP_OKAY || !i_s_axi_wstrb[0]) return;
    if (a % 4 == 2) m[a-'hD2] = exp_rd(a - 'hD2);
    m[a-'hD0] = d[7:0] & (a < 'hD4 ? 8'hFF : 8'h1F);
  endtask
  task automatic rd(int a, logic [31:0] e, logic [1:0] er);
    i_s_axi_araddr <= 12'(a * 4);
    i_s_axi_arvalid <= 1'h1;
    do @(posedge i_clk_sys); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'h0;
    i_s_axi_rready <= 1'h1;
    do @(posedge i_clk_sys); while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'h0;
    chk("rdata", e, o_s_axi_rdata);
    chk("rresp", 32'(er), 32'(o_s_axi_rresp));
  endtask
  // Settle pins, then compare registers, drives and requests
  task automatic check_all;
    logic [7:0] q;
    repeat (4) @(posedge i_clk_sys);
    for (int k = 0; k < 8; k++) rd('hD0 + k, 32'(exp_rd(k)), dpg_pkg::RESP_OKAY);
    chk("pa_oe", 32'(m[2] & ~(m[3] & m[1])), 32'(o_pa_pin_oe));
    chk("pa_out", 32'(m[1]), 32'(o_pa_pin));
    chk("pb_oe", 32'(m[6]), 32'(o_pb_pin_oe));
    chk("pb_out", 32'(m[5]), 32'(o_pb_pin));
    q = m[7] & ~m[6] & ~lvl(1);
    chk("req", 32'({q[0], q[2], q[4]}),
      32'({o_portb_pin_zero_recovery, o_external_interrupt_three, o_external_interrupt_one_four}));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    check_all;
    wr('hE0, 32'hA5, dpg_pkg::RESP_SLVERR);
    rd('hE0, 32'h0, dpg_pkg::RESP_SLVERR);
    check_all;
    $display("test reset and unmapped done");
    wr('hD7, 32'h0, dpg_pkg::RESP_OKAY);
    wr('hD6, 32'h0, dpg_pkg::RESP_OKAY);
    wr('hD7, 32'h1F, dpg_pkg::RESP_OKAY);
    ee[1] <= 8'hFF;
    check_all;
    wr('hD6, 32'h15, dpg_pkg::RESP_OKAY);
    check_all;
    $display("test port b functions done");
    repeat (40) begin
      i_s_axi_wstrb <= 4'($random(seed));
      wr('hD0 + ($unsigned($random(seed)) % 8), $random(seed), dpg_pkg::RESP_OKAY);
      ev[0] <= 8'($random(seed));
      ev[1] <= 8'($random(seed));
      ee[0] <= 8'($random(seed));
      ee[1] <= 8'($random(seed));
      check_all;
    end
    $display("test random traffic done");
    give_verdict;
  end
endmodule
bind dpg_top dpg_assertions #(.PA_W(PA_W), .PB_W(PB_W)) chk (.i_clk_sys, .i_rst, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_bresp, .o_s_axi_rdata, .o_pa_pin, .o_pa_pin_oe,
  .i_pb_pin, .o_pb_pin, .o_pb_pin_oe, .o_portb_pin_zero_recovery, .o_external_interrupt_three,
  .o_external_interrupt_one_four);
